// [rtl/dsl_byte_gather.v]
`timescale 1ns/1ps
// Finds the lane, if any, that carries one CPU byte on a read.
module dsl_byte_gather #(
   parameter [1:0] BYTE_NUM = 2'h0
) (
   input wire [31:0] lanes,
   input wire [3:0] lane_en,
   input wire [7:0] lane_idx,
   output reg hit,
   output reg [7:0] value
);
   integer n;
   always @* begin
      hit = 1'b0;
      value = 8'h00;
      for (n = 0; n < 4; n = n + 1) begin
         if (lane_en[n] && lane_idx[2*n +: 2] == BYTE_NUM) begin
            hit = 1'b1;
            value = lanes[8*n +: 8];
         end
      end
   end
endmodule // dsl_byte_gather

// [rtl/dsl_lane_mux.v]
`timescale 1ns/1ps
// Picks the CPU byte that one data lane carries on a write.
module dsl_lane_mux (
   input wire [31:0] cpu_data,
   input wire [1:0] byte_idx,
   input wire lane_en,
   output reg [7:0] lane_byte
);
   always @* begin
      lane_byte = 8'h00;
      if (lane_en) begin
         case (byte_idx)
            2'h0: lane_byte = cpu_data[7:0];
            2'h1: lane_byte = cpu_data[15:8];
            2'h2: lane_byte = cpu_data[23:16];
            default: lane_byte = cpu_data[31:24];
         endcase
      end
   end
endmodule // dsl_lane_mux

// [rtl/dsl_regs.vh]
`ifndef DSL_REGS_VH
`define DSL_REGS_VH

// Access size codes on req_size.
`define DSL_SIZE_WORD 2'h0
`define DSL_SIZE_TRIPLE 2'h1
`define DSL_SIZE_HALF 2'h2
`define DSL_SIZE_BYTE 2'h3

// Bank width field codes.
`define DSL_WIDTH_32 2'h0
`define DSL_WIDTH_16 2'h1
`define DSL_WIDTH_8 2'h2
`define DSL_WIDTH_RSVD 2'h3

// Low host address values.
`define DSL_ADDR_00 2'h0
`define DSL_ADDR_01 2'h1
`define DSL_ADDR_10 2'h2
`define DSL_ADDR_11 2'h3

// Transfer step numbers and counts.
`define DSL_STEP_0 2'h0
`define DSL_STEP_1 2'h1
`define DSL_COUNT_1 2'h0
`define DSL_COUNT_2 2'h1
`define DSL_COUNT_3 2'h2
`define DSL_COUNT_4 2'h3

// Lane enable sets, bit n set means lane n carries a byte.
`define DSL_EN_NONE 4'h0
`define DSL_EN_ALL 4'hF
`define DSL_EN_L3 4'h8
`define DSL_EN_L2 4'h4
`define DSL_EN_L32 4'hC
`define DSL_EN_L10 4'h3
`define DSL_EN_L321 4'hE
`define DSL_EN_L210 4'h7
`define DSL_EN_L0 4'h1

// Byte index values.
`define DSL_BYTE_0 2'h0
`define DSL_BYTE_1 2'h1
`define DSL_BYTE_2 2'h2
`define DSL_BYTE_3 2'h3

// Idle levels of the active-low strobes and masks.
`define DSL_STROBE_IDLE 4'hF
`define DSL_MASK_IDLE 1'h1
`define DSL_DATA_ZERO 32'h0000_0000

// Decode vector layout: addr, enables, lane 3..0 byte indices.
`define DSL_DEC_W 14
`define DSL_DEC_ADDR 13:12
`define DSL_DEC_EN 11:8
`define DSL_DEC_IDX 7:0

`endif

// [rtl/dsl_steer.v]
`timescale 1ns/1ps
`include "dsl_regs.vh"
// Summary of operation
// - 16-bit SDRAM word: two transfers at 00 and 10 on upper two lanes.
// - 16-bit SDRAM triple at 01: upper lane only first, both lanes at 10.
// - 16-bit SDRAM triple at 00: both lanes first, lane 23:16 alone at 10.
// - 16-bit SDRAM half-word: one transfer, both masks enabled.
// - 16-bit SDRAM byte: even address on lane 23:16, odd on 31:24.
// - 8-bit SDRAM: lane 31:24 only, masks LH, word in four byte transfers.
// - 8-bit SDRAM triple byte: three transfers from the start address.
// - 8-bit SDRAM half-word: two transfers at consecutive addresses.
// - 8-bit SDRAM byte: one transfer, byte on lane 31:24.
// - Bus width comes from the selected bank's two-bit width field.
// - 32-bit DRAM word: all strobes enabled, bytes pass straight through.
// - 32-bit DRAM triple: HLLL at 00, LLLH at 01, bytes straight.
// - 32-bit DRAM half-word: HHLL at 00, LLHH at 10 with shifted data.
// - 32-bit DRAM byte: exactly one strobe low, chosen by address.
// - 16-bit DRAM: upper lanes only, lower strobes stay high.
// - 16-bit DRAM partial accesses use the fixed strobe patterns.
// - DRAM strobe patterns apply on reads as well as writes.
// - Lanes carrying no byte are don't-care and are ignored on reads.
// - Lanes, strobes and masks use little-endian naming.
module dsl_steer (
   input wire mclk,
   input wire reset,
   input wire req_valid,
   input wire req_write,
   input wire req_dram,
   input wire req_bank,
   input wire [1:0] req_size,
   input wire [1:0] host_low_address,
   input wire [31:0] req_wdata,
   input wire [1:0] bank_width_field0,
   input wire [1:0] bank_width_field1,
   input wire xfer_ack,
   input wire [31:0] rd_lane_le,
   output reg busy,
   output reg req_reject,
   output reg xfer_active,
   output reg [1:0] xfer_addr,
   output reg [31:0] data_lane_le,
   output reg data_lane_oe,
   output reg upper_lane_mask_le,
   output reg lower_lane_mask_le,
   output reg [3:0] column_strobe_le,
   output reg access_done,
   output reg [31:0] rd_data
);

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_XFER = 3'h2;
   localparam [2:0] ST_DONE = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg cap_write;
   reg cap_dram;
   reg [1:0] cap_size;
   reg [1:0] cap_addr;
   reg [1:0] cap_width;
   reg [31:0] cap_wdata;
   reg [1:0] step;
   reg [1:0] last_step;
   reg [3:0] cur_en;
   reg [7:0] cur_idx;
   reg [1:0] req_width;
   reg req_legal;
   reg load_req;
   reg advance;
   reg [1:0] dec_width;
   reg [1:0] dec_size;
   reg [1:0] dec_addr;
   reg [1:0] dec_step;
   reg dec_dram;
   reg [31:0] dec_wdata;
   reg dec_write;
   reg [`DSL_DEC_W-1:0] dec;
   reg next_upper_mask;
   reg next_lower_mask;
   reg [3:0] next_strobe;
   wire [31:0] next_lanes;
   wire [3:0] gather_hit;
   wire [31:0] gather_value;

   // Lane enables and byte indices for one transfer step.
   function [`DSL_DEC_W-1:0] dsl_decode;
      input [1:0] width;
      input [1:0] size;
      input [1:0] addr;
      input [1:0] stp;
      reg [1:0] xa;
      reg [3:0] en;
      reg [1:0] i3;
      reg [1:0] i2;
      reg [1:0] i1;
      reg [1:0] i0;
      reg [1:0] first;
      reg [1:0] shift;
      begin
         xa = addr;
         en = `DSL_EN_NONE;
         i3 = `DSL_BYTE_0;
         i2 = `DSL_BYTE_0;
         i1 = `DSL_BYTE_0;
         i0 = `DSL_BYTE_0;
         first = `DSL_BYTE_0;
         shift = `DSL_ADDR_00;
         case (width)
            `DSL_WIDTH_8: begin
               en = `DSL_EN_L3;
               if (size == `DSL_SIZE_TRIPLE) begin
                  first = {1'b0, addr[0]};
               end
               i3 = first + stp;
               xa = addr + stp;
               if (size == `DSL_SIZE_BYTE) begin
                  i3 = `DSL_BYTE_0;
                  xa = addr;
               end
            end
            `DSL_WIDTH_16: begin
               en = `DSL_EN_L32;
               i3 = {stp[0], 1'b1};
               i2 = {stp[0], 1'b0};
               xa = stp[0] ? `DSL_ADDR_10 : addr;
               if (size == `DSL_SIZE_TRIPLE) begin
                  if (addr[0] && !stp[0]) begin
                     en = `DSL_EN_L3;
                  end
                  if (!addr[0] && stp[0]) begin
                     en = `DSL_EN_L2;
                  end
               end
               if (size == `DSL_SIZE_HALF) begin
                  xa = addr;
               end
               if (size == `DSL_SIZE_BYTE) begin
                  i3 = `DSL_BYTE_0;
                  i2 = `DSL_BYTE_0;
                  en = addr[0] ? `DSL_EN_L3 : `DSL_EN_L2;
               end
            end
            default: begin
               if (size == `DSL_SIZE_HALF || size == `DSL_SIZE_BYTE) begin
                  shift = addr;
               end
               i3 = `DSL_BYTE_3 - shift;
               i2 = `DSL_BYTE_2 - shift;
               i1 = `DSL_BYTE_1 - shift;
               i0 = `DSL_BYTE_0 - shift;
               case (size)
                  `DSL_SIZE_WORD: en = `DSL_EN_ALL;
                  `DSL_SIZE_TRIPLE: en = addr[0] ? `DSL_EN_L321 : `DSL_EN_L210;
                  `DSL_SIZE_HALF: en = addr[1] ? `DSL_EN_L32 : `DSL_EN_L10;
                  default: en = `DSL_EN_L0 << addr;
               endcase
            end
         endcase
         dsl_decode = {xa, en, i3, i2, i1, i0};
      end
   endfunction

   // Index of the final transfer step of an access.
   function [1:0] dsl_last;
      input [1:0] width;
      input [1:0] size;
      begin
         dsl_last = `DSL_COUNT_1;
         if (width == `DSL_WIDTH_8) begin
            case (size)
               `DSL_SIZE_WORD: dsl_last = `DSL_COUNT_4;
               `DSL_SIZE_TRIPLE: dsl_last = `DSL_COUNT_3;
               `DSL_SIZE_HALF: dsl_last = `DSL_COUNT_2;
               default: dsl_last = `DSL_COUNT_1;
            endcase
         end else if (width == `DSL_WIDTH_16) begin
            if (size == `DSL_SIZE_WORD || size == `DSL_SIZE_TRIPLE) begin
               dsl_last = `DSL_COUNT_2;
            end
         end
      end
   endfunction

   always @* begin
      req_width = req_bank ? bank_width_field1 : bank_width_field0;
   end

   // Misaligned sizes and the reserved width are refused.
   always @* begin
      req_legal = (req_width != `DSL_WIDTH_RSVD);
      case (req_size)
         `DSL_SIZE_WORD: begin
            if (host_low_address != `DSL_ADDR_00) begin
               req_legal = 1'b0;
            end
         end
         `DSL_SIZE_TRIPLE: begin
            if (host_low_address[1]) begin
               req_legal = 1'b0;
            end
         end
         `DSL_SIZE_HALF: begin
            if (host_low_address[0]) begin
               req_legal = 1'b0;
            end
         end
         default: begin
         end
      endcase
   end

   always @* begin
      load_req = (state == ST_IDLE) && req_valid && req_legal;
      advance = (state == ST_XFER) && xfer_ack && (step != last_step);
   end

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (load_req) begin
               next_state = ST_XFER;
            end
         end
         ST_XFER: begin
            if (xfer_ack && step == last_step) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Decode the step whose outputs appear on the next edge.
   always @* begin
      if (state == ST_IDLE) begin
         dec_width = req_width;
         dec_size = req_size;
         dec_addr = host_low_address;
         dec_step = `DSL_STEP_0;
         dec_dram = req_dram;
         dec_wdata = req_wdata;
         dec_write = req_write;
      end else begin
         dec_width = cap_width;
         dec_size = cap_size;
         dec_addr = cap_addr;
         dec_step = step + `DSL_STEP_1;
         dec_dram = cap_dram;
         dec_wdata = cap_wdata;
         dec_write = cap_write;
      end
      dec = dsl_decode(dec_width, dec_size, dec_addr, dec_step);
   end

   always @* begin
      next_strobe = `DSL_STROBE_IDLE;
      next_upper_mask = `DSL_MASK_IDLE;
      next_lower_mask = `DSL_MASK_IDLE;
      if (dec_dram) begin
         next_strobe = ~dec[`DSL_DEC_EN];
         if (dec_width == `DSL_WIDTH_16) begin
            next_strobe[1:0] = 2'h3;
         end
      end else if (dec_width == `DSL_WIDTH_32) begin
         next_upper_mask = ~(dec[11] | dec[10]);
         next_lower_mask = ~(dec[9] | dec[8]);
      end else begin
         next_upper_mask = ~dec[11];
         next_lower_mask = ~dec[10];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : lanes
         dsl_lane_mux u_mux (
            .cpu_data(dec_wdata),
            .byte_idx(dec[2*g +: 2]),
            .lane_en(dec[8 + g] & dec_write),
            .lane_byte(next_lanes[8*g +: 8])
         );
         dsl_byte_gather #(
            .BYTE_NUM(g[1:0])
         ) u_gather (
            .lanes(rd_lane_le),
            .lane_en(cur_en),
            .lane_idx(cur_idx),
            .hit(gather_hit[g]),
            .value(gather_value[8*g +: 8])
         );
      end
   endgenerate

   always @(posedge mclk) begin
      if (reset) begin
         state <= ST_IDLE;
         step <= `DSL_STEP_0;
         last_step <= `DSL_COUNT_1;
         cap_write <= 1'b0;
         cap_dram <= 1'b0;
         cap_size <= `DSL_SIZE_WORD;
         cap_addr <= `DSL_ADDR_00;
         cap_width <= `DSL_WIDTH_32;
         cap_wdata <= `DSL_DATA_ZERO;
      end else begin
         state <= next_state;
         if (load_req) begin
            step <= `DSL_STEP_0;
            last_step <= dsl_last(req_width, req_size);
            cap_write <= req_write;
            cap_dram <= req_dram;
            cap_size <= req_size;
            cap_addr <= host_low_address;
            cap_width <= req_width;
            cap_wdata <= req_wdata;
         end else if (advance) begin
            step <= step + `DSL_STEP_1;
         end
      end
   end

   // Pin-facing outputs, held until the step is acknowledged.
   always @(posedge mclk) begin
      if (reset) begin
         xfer_active <= 1'b0;
         xfer_addr <= `DSL_ADDR_00;
         data_lane_le <= `DSL_DATA_ZERO;
         data_lane_oe <= 1'b0;
         upper_lane_mask_le <= `DSL_MASK_IDLE;
         lower_lane_mask_le <= `DSL_MASK_IDLE;
         column_strobe_le <= `DSL_STROBE_IDLE;
         cur_en <= `DSL_EN_NONE;
         cur_idx <= 8'h00;
      end else if (load_req || advance) begin
         xfer_active <= 1'b1;
         xfer_addr <= dec[`DSL_DEC_ADDR];
         data_lane_le <= next_lanes;
         data_lane_oe <= dec_write;
         upper_lane_mask_le <= next_upper_mask;
         lower_lane_mask_le <= next_lower_mask;
         column_strobe_le <= next_strobe;
         cur_en <= dec[`DSL_DEC_EN];
         cur_idx <= dec[`DSL_DEC_IDX];
      end else if (state == ST_XFER && xfer_ack) begin
         xfer_active <= 1'b0;
         xfer_addr <= `DSL_ADDR_00;
         data_lane_le <= `DSL_DATA_ZERO;
         data_lane_oe <= 1'b0;
         upper_lane_mask_le <= `DSL_MASK_IDLE;
         lower_lane_mask_le <= `DSL_MASK_IDLE;
         column_strobe_le <= `DSL_STROBE_IDLE;
         cur_en <= `DSL_EN_NONE;
      end
   end

   integer b;
   // read bytes gathered only from carrying lanes
   always @(posedge mclk) begin
      if (reset) begin
         rd_data <= `DSL_DATA_ZERO;
      end else if (load_req) begin
         rd_data <= `DSL_DATA_ZERO;
      end else if (state == ST_XFER && xfer_ack && !cap_write) begin
         for (b = 0; b < 4; b = b + 1) begin
            if (gather_hit[b]) begin
               rd_data[8*b +: 8] <= gather_value[8*b +: 8];
            end
         end
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         busy <= 1'b0;
         req_reject <= 1'b0;
         access_done <= 1'b0;
      end else begin
         busy <= (next_state != ST_IDLE);
         req_reject <= (state == ST_IDLE) && req_valid && !req_legal;
         access_done <= (state == ST_XFER) && xfer_ack && (step == last_step);
      end
   end

endmodule // dsl_steer

// [tb/dsl_mem_model.sv]
`timescale 1ns/1ps
// Memory side: acks each transfer and returns a lane-coded read pattern.
module dsl_mem_model (
   input logic mclk,
   input logic reset,
   input logic slow,
   input logic xfer_active,
   input logic data_lane_oe,
   input logic [1:0] xfer_addr,
   output logic xfer_ack,
   output logic [31:0] rd_lane_le
);
   logic [1:0] wait_cnt;
   logic [31:0] pat;
   // Lane k returns address, k, 9; inverse when not read.
   assign pat = {xfer_addr, 6'h39, xfer_addr, 6'h29, xfer_addr, 6'h19,
      xfer_addr, 6'h09};
   assign rd_lane_le = (xfer_active && !data_lane_oe) ? pat : ~pat;
   always @(posedge mclk) begin
      if (reset) begin
         xfer_ack <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (xfer_active && !xfer_ack) begin
         xfer_ack <= slow ? (wait_cnt == 2'h3) : 1'b1;
         wait_cnt <= slow ? wait_cnt + 2'h1 : 2'h0;
      end else begin
         xfer_ack <= 1'b0;
         wait_cnt <= 2'h0;
      end
   end
endmodule // dsl_mem_model

// [tb/dsl_steer_asserts.sv]
`timescale 1ns/1ps
module dsl_steer_chk (
   input logic mclk,
   input logic reset,
   input logic req_valid,
   input logic busy,
   input logic req_reject,
   input logic xfer_active,
   input logic xfer_ack,
   input logic [1:0] xfer_addr,
   input logic [31:0] data_lane_le,
   input logic data_lane_oe,
   input logic upper_lane_mask_le,
   input logic lower_lane_mask_le,
   input logic [3:0] column_strobe_le,
   input logic access_done
);
   wire masks_off = upper_lane_mask_le && lower_lane_mask_le;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   idle_levels_a: assert property (
      !xfer_active |-> column_strobe_le == 4'hF && masks_off && !data_lane_oe)
      else $error("lane selects active with no transfer");
   one_kind_a: assert property (
      !masks_off |-> column_strobe_le == 4'hF)
      else $error("masks and strobes active together");
   some_lane_a: assert property (
      xfer_active |-> !masks_off || column_strobe_le != 4'hF)
      else $error("transfer enables no lane");
   hold_step_a: assert property (
      xfer_active && !xfer_ack |=> xfer_active && $stable(xfer_addr)
         && $stable(column_strobe_le) && $stable(data_lane_le))
      else $error("transfer changed before its ack");
   accept_a: assert property (
      !busy && !xfer_active && !req_reject && req_valid
         |=> xfer_active || req_reject)
      else $error("idle request neither started nor refused");
   done_cause_a: assert property (
      access_done |-> $past(xfer_active) && $past(xfer_ack) && !xfer_active)
      else $error("done without a final acked transfer");
   busy_release_a: assert property (
      access_done |-> busy ##1 (!busy && !access_done))
      else $error("busy not released one cycle after done");
   reject_pulse_a: assert property (
      req_reject |-> !xfer_active ##1 !req_reject)
      else $error("refusal not a single idle pulse");
   cover property (access_done && $past(data_lane_oe));
   cover property (req_reject);
   cover property (xfer_active && xfer_ack && column_strobe_le != 4'hF
      && !data_lane_oe);
endmodule // dsl_steer_chk

bind dsl_steer dsl_steer_chk i_dsl_steer_chk (.mclk, .reset, .req_valid,
   .busy, .req_reject, .xfer_active, .xfer_ack, .xfer_addr, .data_lane_le,
   .data_lane_oe, .upper_lane_mask_le, .lower_lane_mask_le,
   .column_strobe_le, .access_done);

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "dsl_regs.vh"
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
   fails++; $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb_top;
   logic mclk = 0, reset = 1, req_valid = 0, req_write = 0, req_dram = 0;
   logic req_bank = 0, slow = 0, xfer_ack, busy, req_reject, xfer_active;
   logic data_lane_oe, upper_lane_mask_le, lower_lane_mask_le, access_done;
   logic [1:0] req_size = 0, host_low_address = 0, xfer_addr;
   logic [1:0] bank_width_field0 = 0, bank_width_field1 = 0;
   logic [31:0] req_wdata = 32'h4433_2211, rd_lane_le, data_lane_le;
   logic [31:0] rd_data, rdv;
   logic [3:0] column_strobe_le;
   logic [1:0] qa[$];
   logic [31:0] ql[$];
   logic [5:0] qs[$];
   int fails = 0, checks_done = 0;
   dsl_steer i_dsl_steer (.mclk, .reset, .req_valid, .req_write, .req_dram,
      .req_bank, .req_size, .host_low_address, .req_wdata, .bank_width_field0,
      .bank_width_field1, .xfer_ack, .rd_lane_le, .busy, .req_reject,
      .xfer_active, .xfer_addr, .data_lane_le, .data_lane_oe,
      .upper_lane_mask_le, .lower_lane_mask_le, .column_strobe_le,
      .access_done, .rd_data);
   dsl_mem_model i_dsl_mem_model (.mclk, .reset, .slow, .xfer_active,
      .data_lane_oe, .xfer_addr, .xfer_ack, .rd_lane_le);
   always #5 mclk = ~mclk;
   // Records every transfer at the edge that acks it.
   always @(posedge mclk) if (xfer_active === 1'b1 && xfer_ack === 1'b1) begin
      qa.push_back(xfer_addr);
      ql.push_back(data_lane_le);
      qs.push_back({column_strobe_le, upper_lane_mask_le, lower_lane_mask_le});
   end
   task automatic report_and_stop;
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run(input int d, w, b, input logic [1:0] sz, input int a, ns);
      int n;
      @(posedge mclk);
      req_valid <= 1'b1;
      req_dram <= d[0];
      req_write <= w[0];
      req_bank <= b[0];
      req_size <= sz;
      host_low_address <= a[1:0];
      @(posedge mclk);
      req_valid <= 1'b0;
      n = 0;
      // Sample settled outputs away from the launching edge.
      @(negedge mclk);
      while (access_done !== 1'b1 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      `CHK("access_done", 1'b1, access_done)
      `CHK("steps", ns, qa.size())
      rdv = rd_data;
   endtask
   task automatic step(input int a, en, idx, pat);
      logic [31:0] l;
      logic [5:0] s;
      logic [1:0] ad;
      ad = qa.pop_front();
      l = ql.pop_front();
      s = qs.pop_front();
      `CHK("xfer_addr", a[1:0], ad)
      `CHK("selects", req_dram ? {pat[3:0], 2'h3} : {4'hF, pat[1:0]}, s)
      for (int k = 0; k < 4; k++) if (en[k]) begin
         if (req_write) `CHK("lane", req_wdata[idx[2*k+:2]*8+:8], l[k*8+:8])
         else `CHK("rd_byte", {a[1:0], k[1:0], 4'h9}, rdv[idx[2*k+:2]*8+:8])
      end
   endtask
   task automatic t_sd16;
      bank_width_field0 <= `DSL_WIDTH_16;
      bank_width_field1 <= `DSL_WIDTH_8;
      run(0, 1, 0, `DSL_SIZE_WORD, 0, 2);
      step(0, 4'hC, 8'h40, 0);
      step(2, 4'hC, 8'hE0, 0);
      run(0, 1, 0, `DSL_SIZE_TRIPLE, 1, 2);
      step(1, 4'h8, 8'h40, 1);
      step(2, 4'hC, 8'hE0, 0);
      run(0, 1, 0, `DSL_SIZE_TRIPLE, 0, 2);
      step(0, 4'hC, 8'h40, 0);
      step(2, 4'h4, 8'h20, 2);
      run(0, 1, 0, `DSL_SIZE_HALF, 2, 1);
      step(2, 4'hC, 8'h40, 0);
      for (int a = 0; a < 4; a++) begin
         run(0, 1, 0, `DSL_SIZE_BYTE, a, 1);
         step(a, a[0] ? 4'h8 : 4'h4, 8'h00, a[0] ? 1 : 2);
      end
   endtask
   task automatic t_sd8;
      slow <= 1'b1;
      run(0, 1, 1, `DSL_SIZE_WORD, 0, 4);
      for (int s = 0; s < 4; s++) step(s, 4'h8, s << 6, 1);
      slow <= 1'b0;
      run(0, 1, 1, `DSL_SIZE_TRIPLE, 1, 3);
      for (int s = 1; s < 4; s++) step(s, 4'h8, s << 6, 1);
      run(0, 1, 1, `DSL_SIZE_HALF, 2, 2);
      for (int s = 0; s < 2; s++) step(s + 2, 4'h8, s << 6, 1);
      run(0, 1, 1, `DSL_SIZE_BYTE, 3, 1);
      step(3, 4'h8, 8'h00, 1);
   endtask
   task automatic t_dr32;
      bank_width_field0 <= `DSL_WIDTH_32;
      run(1, 0, 0, `DSL_SIZE_WORD, 0, 1);
      step(0, 4'hF, 8'hE4, 4'h0);
      run(1, 1, 0, `DSL_SIZE_TRIPLE, 0, 1);
      step(0, 4'h7, 8'hE4, 4'h8);
      run(1, 0, 0, `DSL_SIZE_TRIPLE, 1, 1);
      step(1, 4'hE, 8'hE4, 4'h1);
      run(1, 1, 0, `DSL_SIZE_HALF, 0, 1);
      step(0, 4'h3, 8'hE4, 4'hC);
      run(1, 0, 0, `DSL_SIZE_HALF, 2, 1);
      step(2, 4'hC, 8'h40, 4'h3);
      for (int a = 0; a < 4; a++) begin
         run(1, a[0], 0, `DSL_SIZE_BYTE, a, 1);
         step(a, 1 << a, 8'h00, ~(1 << a));
      end
   endtask
   task automatic t_dr16;
      bank_width_field0 <= `DSL_WIDTH_16;
      run(1, 0, 0, `DSL_SIZE_WORD, 0, 2);
      step(0, 4'hC, 8'h40, 4'h3);
      step(2, 4'hC, 8'hE0, 4'h3);
      run(1, 1, 0, `DSL_SIZE_TRIPLE, 1, 2);
      step(1, 4'h8, 8'h40, 4'h7);
      step(2, 4'hC, 8'hE0, 4'h3);
      run(1, 1, 0, `DSL_SIZE_TRIPLE, 0, 2);
      step(0, 4'hC, 8'h40, 4'h3);
      step(2, 4'h4, 8'h20, 4'hB);
      for (int a = 0; a < 4; a++) begin
         run(1, 0, 0, `DSL_SIZE_BYTE, a, 1);
         step(a, a[0] ? 4'h8 : 4'h4, 8'h00, a[0] ? 4'h7 : 4'hB);
      end
   endtask
   task automatic t_reject;
      @(posedge mclk);
      req_valid <= 1'b1;
      req_size <= `DSL_SIZE_WORD;
      host_low_address <= 2'h1;
      @(posedge mclk);
      req_valid <= 1'b0;
      @(negedge mclk);
      `CHK("req_reject", 1'b1, req_reject)
      `CHK("xfer_active", 1'b0, xfer_active)
   endtask
   initial begin
      #100us;
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_sd16;
      t_sd8;
      t_dr32;
      t_dr16;
      t_reject;
      repeat (3) @(posedge mclk);
      report_and_stop;
   end
endmodule // tb_top
